// *** core/pcc_defines.vh ***
// constants for the socket control-signal block
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
// battery condition codes
`define PCC_BATT_GOOD      2'h0
`define PCC_BATT_WEAK      2'h1
`define PCC_BATT_LOST      2'h2
// cycle kinds on the command port
`define PCC_CYC_IDLE       3'h0
`define PCC_CYC_IO_RD      3'h1
`define PCC_CYC_IO_WR      3'h2
`define PCC_CYC_DMA_RD     3'h3
`define PCC_CYC_DMA_WR     3'h4
// sequencer states
`define PCC_ST_IDLE        2'h0
`define PCC_ST_SETUP       2'h1
`define PCC_ST_STROBE      2'h2
`define PCC_ST_HOLD        2'h3
// timing counts in clock cycles
`define PCC_SETUP_CYC      4'h2
`define PCC_STROBE_CYC     4'h4
`define PCC_HOLD_CYC       4'h1
`endif

// *** core/pcc_sync.v ***
// two-flop synchroniser bank for card status inputs
`timescale 1ns/1ps
module pcc_sync
#(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)
(
    // clock and reset
    input  wire             i_clk,
    input  wire             i_resetn,
    // raw and synchronised levels
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_bit
            always @(posedge i_clk or negedge i_resetn)
            begin
                if (!i_resetn)
                begin
                    meta_r[g] <= INIT[g];
                    sync_r[g] <= INIT[g];
                end
                else
                begin
                    meta_r[g] <= i_async[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate
    assign o_sync = sync_r;
endmodule // pcc_sync

// *** core/pcc_ctrl.v ***
// control-signal logic for one 16-bit card socket
`timescale 1ns/1ps
`include "pcc_defines.vh"
////////////////////////////////////////////////////////////////////////////
// Contract
// - both battery lines high good; b low weak; a low lost. code reports good in i/o mode.
// - card audio merged into one speaker output, only in i/o mode.
// - both card-detect lines low means card present; reported as status.
// - even_byte_enable selects even bytes, odd_byte_enable odd bytes.
// - in dma mode input_acknowledge may act as the dma request strobe.
// - io read strobe asserted during host i/o read cycles.
// - io read strobe is the dma write strobe, card to memory.
// - io write strobe driven low during host i/o write cycles.
// - io write strobe is the dma strobe, memory to card.
// - dma acknowledge asserted with the read or write strobe in dma.
module pcc_ctrl
(
    // clock and reset
    input  wire       i_ref_clk,
    input  wire       i_resetn,
    // socket configuration
    input  wire       i_io_mode,
    input  wire       i_dma_mode,
    input  wire       i_dma_req_sel,
    input  wire       i_other_audio,
    // host cycle request
    input  wire       i_cyc_valid,
    input  wire [2:0] i_cyc_kind,
    input  wire       i_cyc_addr0,
    input  wire       i_cyc_wide,
    // card status pins, active low where named so
    input  wire       i_battery_detect_a,
    input  wire       i_battery_detect_b,
    input  wire       i_card_detect_a_n,
    input  wire       i_card_detect_b_n,
    input  wire       i_input_acknowledge_n,
    // card strobes, active low
    output reg        o_even_byte_enable_n,
    output reg        o_odd_byte_enable_n,
    output reg        o_io_read_strobe_n,
    output reg        o_io_write_strobe_n,
    output reg        o_dma_acknowledge_n,
    // status back to host
    output reg        o_cyc_busy,
    output reg        o_cyc_done,
    output reg        o_input_ack_seen,
    output reg        o_card_present,
    output reg  [1:0] o_card_detect,
    output reg  [1:0] o_battery_state,
    output reg        o_ring_indicate,
    output reg        o_status_change_line,
    output reg        o_dma_request,
    output reg        o_merged_audio_out
);
////////////////////////////////////////////////////////////////////////////
    wire [4:0] sync_w;
    // inputs reset to idle levels: no card, battery good
    pcc_sync #(.WIDTH(5), .INIT(5'h1f)) u_sync
    (
        .i_clk    (i_ref_clk),
        .i_resetn (i_resetn),
        .i_async  ({i_input_acknowledge_n, i_card_detect_b_n,
                    i_card_detect_a_n, i_battery_detect_b,
                    i_battery_detect_a}),
        .o_sync   (sync_w)
    );
    wire bat_a_w  = sync_w[0];
    wire bat_b_w  = sync_w[1];
    wire cd_w     = ~sync_w[2] & ~sync_w[3];
    wire ack_in_w = ~sync_w[4];
////////////////////////////////////////////////////////////////////////////
    // status decode
    reg  [1:0] batt_nxt;
    reg        req_nxt;
    always @*
    begin
        if (!bat_a_w)
            batt_nxt = `PCC_BATT_LOST;
        else if (!bat_b_w)
            batt_nxt = `PCC_BATT_WEAK;
        else
            batt_nxt = `PCC_BATT_GOOD;
        // request source picked by socket setup
        if (!i_dma_mode)
            req_nxt = 1'b0;
        else if (i_dma_req_sel)
            req_nxt = ack_in_w;
        else
            req_nxt = ~bat_b_w;
    end
    reg bat_a_q_r;
    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_card_present       <= 1'b0;
            o_card_detect        <= 2'h3;
            o_battery_state      <= `PCC_BATT_GOOD;
            o_ring_indicate      <= 1'b0;
            o_status_change_line <= 1'b0;
            o_dma_request        <= 1'b0;
            o_merged_audio_out   <= 1'b0;
            bat_a_q_r            <= 1'b1;
        end
        else
        begin
            o_card_present  <= cd_w;
            o_card_detect   <= sync_w[3:2];
            // status-change and ring share the first battery pin
            o_battery_state <= i_io_mode ? `PCC_BATT_GOOD : batt_nxt;
            o_ring_indicate <= i_io_mode & cd_w & ~bat_a_w;
            bat_a_q_r       <= bat_a_w;
            // falling edge of synchronised pin marks a change event
            o_status_change_line <= i_io_mode & cd_w & bat_a_q_r
                                    & ~bat_a_w;
            o_dma_request   <= cd_w & req_nxt;
            // audio honoured only for a present card in i/o mode
            o_merged_audio_out <= (i_io_mode & cd_w & ~i_dma_mode & bat_b_w)
                                  ^ i_other_audio;
        end
    end
////////////////////////////////////////////////////////////////////////////
    // strobe sequencer: setup, strobe, hold
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [3:0] cnt_r;
    reg [3:0] cnt_nxt;
    reg [2:0] kind_r;
    reg       even_r;
    reg       odd_r;
    always @*
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            `PCC_ST_IDLE:
                if (i_cyc_valid && cd_w && i_cyc_kind != `PCC_CYC_IDLE
                    && i_cyc_kind <= `PCC_CYC_DMA_WR)
                begin
                    st_nxt  = `PCC_ST_SETUP;
                    cnt_nxt = `PCC_SETUP_CYC;
                end
            `PCC_ST_SETUP:
                if (cnt_r <= 4'h1)
                begin
                    st_nxt  = `PCC_ST_STROBE;
                    cnt_nxt = `PCC_STROBE_CYC;
                end
                else
                    cnt_nxt = cnt_r - 4'h1;
            `PCC_ST_STROBE:
                if (cnt_r <= 4'h1)
                begin
                    st_nxt  = `PCC_ST_HOLD;
                    cnt_nxt = `PCC_HOLD_CYC;
                end
                else
                    cnt_nxt = cnt_r - 4'h1;
            `PCC_ST_HOLD:
                if (cnt_r <= 4'h1)
                    st_nxt = `PCC_ST_IDLE;
                else
                    cnt_nxt = cnt_r - 4'h1;
            default:
                st_nxt = `PCC_ST_IDLE;
        endcase
    end
    wire start_w  = (st_r == `PCC_ST_IDLE) && (st_nxt == `PCC_ST_SETUP);
    wire strobe_w = (st_nxt == `PCC_ST_STROBE);
    wire active_w = (st_nxt != `PCC_ST_IDLE);
    wire is_dma_w = (kind_r == `PCC_CYC_DMA_RD) ||
                    (kind_r == `PCC_CYC_DMA_WR);
    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_r                 <= `PCC_ST_IDLE;
            cnt_r                <= 4'h0;
            kind_r               <= `PCC_CYC_IDLE;
            even_r               <= 1'b0;
            odd_r                <= 1'b0;
            o_even_byte_enable_n <= 1'b1;
            o_odd_byte_enable_n  <= 1'b1;
            o_io_read_strobe_n   <= 1'b1;
            o_io_write_strobe_n  <= 1'b1;
            o_dma_acknowledge_n  <= 1'b1;
            o_cyc_busy           <= 1'b0;
            o_cyc_done           <= 1'b0;
            o_input_ack_seen     <= 1'b0;
        end
        else
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            if (start_w)
            begin
                kind_r <= i_cyc_kind;
                // wide access takes both lanes, else the one addr0 names
                even_r <= i_cyc_wide | ~i_cyc_addr0;
                odd_r  <= i_cyc_wide | i_cyc_addr0;
            end
            o_cyc_busy <= active_w;
            o_cyc_done <= (st_r == `PCC_ST_HOLD) &&
                          (st_nxt == `PCC_ST_IDLE);
            // byte enables span the last setup cycle through hold
            o_even_byte_enable_n <= ~(active_w & ~start_w & even_r);
            o_odd_byte_enable_n  <= ~(active_w & ~start_w & odd_r);
            o_io_read_strobe_n   <= ~(strobe_w &
                ((kind_r == `PCC_CYC_IO_RD)
                 | (kind_r == `PCC_CYC_DMA_WR)));
            o_io_write_strobe_n  <= ~(strobe_w &
                ((kind_r == `PCC_CYC_IO_WR)
                 | (kind_r == `PCC_CYC_DMA_RD)));
            // acknowledge frames the dma cycle from the last setup cycle through hold
            o_dma_acknowledge_n  <= ~(active_w & ~start_w
                                      & is_dma_w);
            // only meaningful in a host read; card owns its timing
            if (start_w)
                o_input_ack_seen <= 1'b0;
            else if (strobe_w && kind_r == `PCC_CYC_IO_RD && ack_in_w)
                o_input_ack_seen <= 1'b1;
        end
    end
endmodule // pcc_ctrl

// *** tb/pcc_ctrl_asserts.sv ***
// port-level assertions for the socket control-signal block
`timescale 1ns/1ps
`include "pcc_defines.vh"
module pcc_chk
(
    input logic i_ref_clk, i_resetn, i_io_mode, i_dma_mode, i_dma_req_sel,
    input logic i_cyc_valid, i_cyc_addr0, i_cyc_wide, i_battery_detect_a,
    input logic i_battery_detect_b, i_input_acknowledge_n, o_cyc_busy,
    input logic o_even_byte_enable_n, o_odd_byte_enable_n, o_cyc_done,
    input logic o_io_read_strobe_n, o_io_write_strobe_n, o_card_present,
    input logic o_dma_acknowledge_n, o_dma_request,
    input logic [2:0] i_cyc_kind,
    input logic [1:0] o_battery_state
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    // $past reaches 3 edges back, so stay quiet that long after reset
    logic [2:0] up_r;
    logic       ok, take, rdk, wrk;
    always_ff @(posedge i_ref_clk or negedge i_resetn)
        if (!i_resetn)
            up_r <= 3'h0;
        else if (up_r != 3'h4)
            up_r <= up_r + 3'h1;
    assign ok   = up_r == 3'h4;
    assign take = !o_cyc_busy && i_cyc_valid && o_card_present &&
                  i_cyc_kind != 3'h0 && i_cyc_kind < 3'h5;
    assign rdk  = i_cyc_kind == `PCC_CYC_IO_RD ||
                  i_cyc_kind == `PCC_CYC_DMA_WR;
    assign wrk  = i_cyc_kind == `PCC_CYC_IO_WR ||
                  i_cyc_kind == `PCC_CYC_DMA_RD;
    a_batt_weak: assert property (
        ok && !$past(i_io_mode) && $past(i_battery_detect_a, 3) &&
        !$past(i_battery_detect_b, 3) |-> o_battery_state == `PCC_BATT_WEAK)
        else $error("battery not weak");
    a_batt_lost: assert property (
        ok && !$past(i_io_mode) && !$past(i_battery_detect_a, 3)
        |-> o_battery_state == `PCC_BATT_LOST) else $error("battery not lost");
    a_dma_ack_req: assert property (
        ok && $past(i_dma_mode) && $past(i_dma_req_sel) && o_card_present &&
        $past(o_card_present)
        |-> o_dma_request == !$past(i_input_acknowledge_n, 3))
        else $error("dma request wrong");
    a_even_sel: assert property (
        take && !i_cyc_wide && !i_cyc_addr0 |-> ##2
        (!o_even_byte_enable_n && o_odd_byte_enable_n) [*6] ##1
        o_even_byte_enable_n) else $error("even enable wrong");
    a_odd_sel: assert property (
        take && !i_cyc_wide && i_cyc_addr0 |-> ##2
        (!o_odd_byte_enable_n && o_even_byte_enable_n) [*6] ##1
        o_odd_byte_enable_n) else $error("odd enable wrong");
    a_read_strobe: assert property (
        take && rdk |-> ##3 (!o_io_read_strobe_n && o_io_write_strobe_n) [*4]
        ##1 o_io_read_strobe_n) else $error("read strobe wrong");
    a_write_strobe: assert property (
        take && wrk |-> ##3 (!o_io_write_strobe_n && o_io_read_strobe_n) [*4]
        ##1 o_io_write_strobe_n) else $error("write strobe wrong");
    a_dma_ack: assert property (
        take && i_cyc_kind >= `PCC_CYC_DMA_RD |-> ##1 o_dma_acknowledge_n ##1
        !o_dma_acknowledge_n [*6] ##1 o_dma_acknowledge_n)
        else $error("dma acknowledge wrong");
    a_done_time: assert property (
        take |-> ##1 (o_cyc_busy && !o_cyc_done) [*7] ##1
        (o_cyc_done && !o_cyc_busy)) else $error("done not on time");
endmodule // pcc_chk
bind pcc_ctrl pcc_chk i_chk (.*);

// *** tb/pcc_card_model.sv ***
// behavioural 16-bit card on the far side of the socket
`timescale 1ns/1ps
module pcc_card_model
(
    // bench controls
    input  logic       i_inserted,
    input  logic       i_answer,
    input  logic       i_dma_req,
    input  logic [1:0] i_batt,
    // socket strobes
    input  logic       i_io_read_strobe_n,
    input  logic       i_even_byte_enable_n,
    // card pins, pulled up by the socket when no card
    output logic       o_card_detect_a_n,
    output logic       o_card_detect_b_n,
    output logic       o_battery_detect_a,
    output logic       o_battery_detect_b,
    output logic       o_input_acknowledge_n
);
    assign o_card_detect_a_n = !i_inserted;
    assign o_card_detect_b_n = !i_inserted;
    // a doubles as ring and status change, b as audio and dma request
    assign o_battery_detect_a = i_batt[1] || !i_inserted;
    assign o_battery_detect_b = i_batt[0] || !i_inserted;
    // ack only while our read strobe is up, or as a dma request
    assign o_input_acknowledge_n = !(i_inserted &&
        (i_dma_req ||
         (i_answer && !i_io_read_strobe_n
          && !i_even_byte_enable_n)));
endmodule // pcc_card_model

// *** tb/pcc_ctrl_tb_top.sv ***
// self-checking bench for the socket control-signal block
`timescale 1ns/1ps
`include "pcc_defines.vh"
module pcc_ctrl_tb_top;
    logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_io_mode = 1'b0;
    logic i_dma_mode = 1'b0, i_dma_req_sel = 1'b0, i_other_audio = 1'b0;
    logic i_cyc_valid = 1'b0, i_cyc_addr0 = 1'b0, i_cyc_wide = 1'b0;
    logic ins = 1'b0, ans = 1'b1, dreq = 1'b0, bda, bdb, cdan, cdbn, ackn;
    logic en, on, rn, wn, dkn, busy, done, seen, pres, ring, stc, dro, aud;
    logic [2:0] i_cyc_kind = 3'h0;
    logic [1:0] batt = 2'h3, det, bst;
    int   err_total = 0, checks_done = 0;
    always #4 i_ref_clk = ~i_ref_clk;
    pcc_card_model i_card (.i_inserted(ins), .i_answer(ans), .i_dma_req(dreq),
        .i_batt(batt), .i_io_read_strobe_n(rn), .i_even_byte_enable_n(en),
        .o_card_detect_a_n(cdan), .o_card_detect_b_n(cdbn),
        .o_battery_detect_a(bda), .o_battery_detect_b(bdb),
        .o_input_acknowledge_n(ackn));
    pcc_ctrl i_dut (.i_ref_clk, .i_resetn, .i_io_mode, .i_dma_mode,
        .i_dma_req_sel, .i_other_audio, .i_cyc_valid, .i_cyc_kind, .i_cyc_addr0,
        .i_cyc_wide, .i_battery_detect_a(bda), .i_battery_detect_b(bdb),
        .i_card_detect_a_n(cdan), .i_card_detect_b_n(cdbn),
        .i_input_acknowledge_n(ackn), .o_even_byte_enable_n(en),
        .o_odd_byte_enable_n(on), .o_io_read_strobe_n(rn),
        .o_io_write_strobe_n(wn), .o_dma_acknowledge_n(dkn), .o_cyc_busy(busy),
        .o_cyc_done(done), .o_input_ack_seen(seen), .o_card_present(pres),
        .o_card_detect(det), .o_battery_state(bst), .o_ring_indicate(ring),
        .o_status_change_line(stc), .o_dma_request(dro),
        .o_merged_audio_out(aud));
    task automatic chk(input logic [7:0] got, want);
        checks_done++;
        if (got !== want)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // low holds which of even, odd, read, write, dma ack went low
    task automatic run_cyc(input logic [2:0] k, input logic a0, w,
                           input logic [4:0] e, input int en_n);
        logic [4:0] low;
        int         n;
        low = 5'h0;
        n = 0;
        ticks(1);
        {i_cyc_valid, i_cyc_kind, i_cyc_addr0, i_cyc_wide} = {1'b1, k, a0, w};
        ticks(1);
        i_cyc_valid = 1'b0;
        while (done !== 1'b1 && n < 20)
        begin
            low = low | ~{en, on, rn, wn, dkn};
            n++;
            ticks(1);
        end
        chk({6'h0, low[4:3]}, {6'h0, e[4:3]});
        chk({7'h0, low[2]}, {7'h0, e[2]});
        chk({7'h0, low[1]}, {7'h0, e[1]});
        chk({7'h0, low[0]}, {7'h0, e[0]});
        chk(8'(n), 8'(en_n));
    endtask
    task automatic t_batt;
        logic [1:0] pin [3] = '{2'h3, 2'h2, 2'h1};
        logic [1:0] code [3] = '{`PCC_BATT_GOOD, `PCC_BATT_WEAK, `PCC_BATT_LOST};
        for (int i = 0; i < 3; i++)
        begin
            batt = pin[i];
            ticks(4);
            chk({6'h0, bst}, {6'h0, code[i]});
        end
        batt = 2'h3;
    endtask
    task automatic t_cycles;
        run_cyc(`PCC_CYC_IO_RD, 1'b0, 1'b0, 5'h14, 7);
        chk({7'h0, seen}, 8'h1);
        ans = 1'b0;
        run_cyc(`PCC_CYC_IO_RD, 1'b0, 1'b0, 5'h14, 7);
        chk({7'h0, seen}, 8'h0);
        run_cyc(`PCC_CYC_IO_WR, 1'b1, 1'b0, 5'h0a, 7);
        run_cyc(`PCC_CYC_DMA_RD, 1'b0, 1'b1, 5'h1b, 7);
        run_cyc(`PCC_CYC_DMA_WR, 1'b0, 1'b0, 5'h15, 7);
        run_cyc(3'h5, 1'b0, 1'b0, 5'h00, 20);
    endtask
    task automatic t_status;
        int cnt;
        cnt = 0;
        {i_dma_mode, i_dma_req_sel, dreq} = 3'h7;
        ticks(4);
        chk({7'h0, dro}, 8'h1);
        {i_dma_req_sel, dreq} = 2'h0;
        batt = 2'h2;
        ticks(4);
        chk({7'h0, dro}, 8'h1);
        batt = 2'h3;
        ticks(4);
        chk({7'h0, dro}, 8'h0);
        {i_dma_mode, dreq, i_io_mode} = 3'h1;
        ticks(4);
        chk({5'h0, aud, bst}, 8'h4);
        i_other_audio = 1'b1;
        ticks(4);
        chk({7'h0, aud}, 8'h0);
        batt = 2'h1;
        repeat (6)
        begin
            ticks(1);
            cnt += stc;
        end
        chk({ring, 7'(cnt)}, 8'h81);
    endtask
    initial
    begin
        ticks(10);
        i_resetn = 1'b1;
        ticks(4);
        chk({5'h0, pres, det}, 8'h3);
        ins = 1'b1;
        ticks(4);
        chk({5'h0, pres, det}, 8'h4);
        t_batt;
        t_cycles;
        t_status;
        tally_and_finish;
    end
    // whole run is about 130 cycles
    initial
    begin
        #20000;
        err_total++;
        tally_and_finish;
    end
endmodule // pcc_ctrl_tb_top
